// ==== core/dslc_regs.sv ====
// dither, sample marker and serial link control register bank
// How it works
// RL1: dither control bit 0 turns dither on; resets to one.
// RL2: dither bit 1 picks large dither when set, small when clear.
// RL3: dither bit 2 moves rounding error from noise to offset and spurs.
// RL4: marker control bit 0 places the timestamp in each sample lsb.
// RL5: the marker is delayed exactly as far as its sample.
// RL6: marker replaces the lsb, leaving 7 of 8 or 11 of 12 bits.
// RL7: the control bit count advertised in lane alignment stays zero.
// RL8: software enabling the marker also enables the sync receiver.
// RL9: link enable bit 0 turns the link on; resets to one.
// RL10: link off holds link reset, powers serializers down, gates clocks.
// RL11: link off keeps the multiframe counter cleared, sysref ignored.
// RL12: software clears link enable before changing other link settings.
// RL13: software sets calibration enable before link enable.
// RL14: software clears link enable before calibration enable.
// RL15: 8-bit link mode register selects mode; resets to mode 2.
// RL16: software writes link mode only with link and calibration off.
// RL17: only modes allowed by the mode-allow mask are taken.
// RL18: multiframe length holds K-1, reset 31, ignored in 64b/66b modes.
// RL19: reserved bits are stored and read back without effect.
`timescale 1ns/10ps
module dslc_regs
(
   // clock and reset
   input  wire  logic                                  REF_CLK,
   input  wire  logic                                  RST_B,
   // serial control port
   input  wire  logic                                  SCLK,
   input  wire  logic                                  SCS_B,
   input  wire  logic                                  SDI,
   output logic                                        SDO,
   output logic                                        SDO_OE,
   // calibration and mode lock state
   input  wire  logic                                  CAL_ON,
   input  wire  logic [dslc_pkg::MODE_ALLOW_W-1:0]     ALLOWED_MODES,
   input  wire  logic                                  MODE_IS_64B66B,
   input  wire  logic [7:0]                            K_FROM_MODE_M1,
   // multiframe timing
   input  wire  logic                                  FRAME_TICK,
   input  wire  logic                                  SYSREF,
   // sample path
   input  wire  logic [dslc_pkg::SAMPLE_W-1:0]         SAMPLE_IN,
   input  wire  logic                                  SAMPLE_8BIT,
   input  wire  logic                                  MARKER_PIN,
   output logic [dslc_pkg::SAMPLE_W-1:0]               SAMPLE_OUT,
   // converter dither
   output logic                                        DITHER_ON,
   output logic                                        DITHER_SIZE_SEL,
   output logic                                        ROUNDING_ERROR_TARGET,
   // serial link control
   output logic                                        LINK_RESET,
   output logic                                        SERIALIZER_PD,
   output logic                                        LINK_CLK_GATE_EN,
   output logic [7:0]                                  LINK_MODE,
   output logic [7:0]                                  FRAMES_PER_MF_M1,
   output logic [7:0]                                  MF_COUNT,
   output logic                                        MF_START,
   output logic [1:0]                                  ILA_CS
);
   logic                              wr_stb;
   logic [dslc_pkg::SPI_ADDR_W-1:0]   acc_addr;
   logic [dslc_pkg::SPI_DATA_W-1:0]   wdata;
   logic [dslc_pkg::SPI_DATA_W-1:0]   rdata;
   logic [7:0]                        dither_control;
   logic [7:0]                        sample_marker_control;
   logic [7:0]                        serial_link_enable;
   logic [7:0]                        multiframe_length;
   logic                              serial_link_on;
   logic                              sample_marker_insert;
   logic [1:0]                        marker_s;
   logic [1:0]                        sysref_s;
   logic                              sysref_d;
   logic                              sysref_rise;
   logic [dslc_pkg::SAMPLE_W-1:0]     sample_d [dslc_pkg::SYNC_DEPTH];
   logic [1:0]                        fmt8_d;
   logic [7:0]                        next_mf_count;

   function automatic logic is_wr(input logic stb, input logic [14:0] a, input logic [14:0] target);
      return stb && (a == target);
   endfunction : is_wr

   function automatic logic mode_allowed(input logic [7:0] mode, input logic [63:0] allow);
      return (mode < dslc_pkg::MODE_LIMIT) && allow[mode[5:0]];
   endfunction : mode_allowed

   dslc_spi u_spi
   (
      .clk       (REF_CLK),
      .rst_b     (RST_B),
      .sclk_pin  (SCLK),
      .scs_b_pin (SCS_B),
      .sdi_pin   (SDI),
      .sdo       (SDO),
      .sdo_oe    (SDO_OE),
      .wr_stb    (wr_stb),
      .acc_addr  (acc_addr),
      .wdata     (wdata),
      .rdata     (rdata)
   );

   assign serial_link_on       = serial_link_enable[dslc_pkg::LINK_ON_BIT];
   assign sample_marker_insert = sample_marker_control[dslc_pkg::MARKER_BIT];

   // whole bytes are stored so reserved bits read back as written
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
         dither_control <= dslc_pkg::RST_DITHER; // see RL1
      else if (is_wr(wr_stb, acc_addr, dslc_pkg::ADDR_DITHER))
         dither_control <= wdata; // see RL19
   end

   assign DITHER_ON             = dither_control[dslc_pkg::DITHER_ON_BIT]; // see RL1
   assign DITHER_SIZE_SEL       = dither_control[dslc_pkg::DITHER_SIZE_BIT]; // see RL2
   assign ROUNDING_ERROR_TARGET = dither_control[dslc_pkg::ROUND_ERR_BIT]; // see RL3

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
         sample_marker_control <= dslc_pkg::RST_MARKER; // see RL4
      else if (is_wr(wr_stb, acc_addr, dslc_pkg::ADDR_MARKER))
         sample_marker_control <= wdata;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
         serial_link_enable <= dslc_pkg::RST_LINK_EN; // see RL9
      else if (is_wr(wr_stb, acc_addr, dslc_pkg::ADDR_LINK_EN))
         serial_link_enable <= wdata; // see RL9
   end

   // a mode write is dropped while the link or calibration runs, or if locked out
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
         LINK_MODE <= dslc_pkg::RST_LINK_MODE; // see RL15
      else if (is_wr(wr_stb, acc_addr, dslc_pkg::ADDR_LINK_MODE) && !serial_link_on && !CAL_ON
               && mode_allowed(wdata, ALLOWED_MODES))
         LINK_MODE <= wdata; // see RL17
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
         multiframe_length <= dslc_pkg::RST_MF_LEN; // see RL18
      else if (is_wr(wr_stb, acc_addr, dslc_pkg::ADDR_MF_LEN))
         multiframe_length <= wdata;
   end

   always_comb
   begin
      unique case (acc_addr)
         dslc_pkg::ADDR_DITHER:    rdata = dither_control;
         dslc_pkg::ADDR_MARKER:    rdata = sample_marker_control;
         dslc_pkg::ADDR_LINK_EN:   rdata = serial_link_enable;
         dslc_pkg::ADDR_LINK_MODE: rdata = LINK_MODE;
         dslc_pkg::ADDR_MF_LEN:    rdata = multiframe_length;
         default:                  rdata = 8'h00;
      endcase
   end

   // link power and reset follow the enable one cycle later
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
      begin
         LINK_RESET       <= 1'b0;
         SERIALIZER_PD    <= 1'b0;
         LINK_CLK_GATE_EN <= 1'b1;
      end
      else
      begin
         LINK_RESET       <= ~serial_link_on; // see RL10
         SERIALIZER_PD    <= ~serial_link_on; // see RL10
         LINK_CLK_GATE_EN <= serial_link_on; // see RL10
      end
   end

   // 64b/66b modes take K from the mode, not from the register
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
         FRAMES_PER_MF_M1 <= dslc_pkg::RST_MF_LEN;
      else
         FRAMES_PER_MF_M1 <= MODE_IS_64B66B ? K_FROM_MODE_M1 : multiframe_length; // see RL18
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
      begin
         sysref_s <= 2'h0;
         sysref_d <= 1'b0;
      end
      else
      begin
         sysref_s <= {sysref_s[0], SYSREF};
         sysref_d <= sysref_s[1];
      end
   end

   assign sysref_rise   = sysref_s[1] & ~sysref_d;
   assign next_mf_count = (MF_COUNT == FRAMES_PER_MF_M1) ? 8'h00 : MF_COUNT + 8'h01;

   // held cleared while the link is off, so sysref cannot realign it
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B || !serial_link_on)
      begin
         MF_COUNT <= 8'h00; // see RL11
         MF_START <= 1'b0;
      end
      else if (sysref_rise)
      begin
         MF_COUNT <= 8'h00;
         MF_START <= 1'b1;
      end
      else if (FRAME_TICK)
      begin
         MF_COUNT <= next_mf_count;
         MF_START <= (next_mf_count == 8'h00);
      end
      else
         MF_START <= 1'b0;
   end

   // the marker is never announced as a control bit
   always_ff @(posedge REF_CLK)
   begin
      ILA_CS <= 2'h0; // see RL7
   end

   // samples wait as long as the marker spends in its synchroniser
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
      begin
         marker_s    <= 2'h0;
         sample_d[0] <= 12'h000;
         sample_d[1] <= 12'h000;
         fmt8_d      <= 2'h0;
      end
      else
      begin
         marker_s    <= {marker_s[0], MARKER_PIN}; // see RL5
         sample_d[0] <= SAMPLE_IN; // see RL5
         sample_d[1] <= sample_d[0];
         fmt8_d      <= {fmt8_d[0], SAMPLE_8BIT};
      end
   end

   // 8-bit samples sit in the upper bits, so their lsb is bit 4
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_B)
         SAMPLE_OUT <= 12'h000;
      else
      begin
         SAMPLE_OUT <= sample_d[1];
         if (sample_marker_insert && fmt8_d[1])
            SAMPLE_OUT[dslc_pkg::MARK_POS_8] <= marker_s[1]; // see RL4 RL6
         else if (sample_marker_insert)
            SAMPLE_OUT[dslc_pkg::MARK_POS_12] <= marker_s[1]; // see RL4 RL6
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   dither_reset_a: assert property (!$past(RST_B) |-> DITHER_ON && !DITHER_SIZE_SEL) // see RL1
      else $error("dither state wrong after reset");
   dither_size_a: assert property (wr_stb && acc_addr == dslc_pkg::ADDR_DITHER // see RL2
                                   |=> DITHER_SIZE_SEL == $past(wdata[1]))
      else $error("dither size does not follow write");
   round_err_a: assert property (wr_stb && acc_addr == dslc_pkg::ADDR_DITHER // see RL3
                                 |=> ROUNDING_ERROR_TARGET == $past(wdata[2]) && DITHER_ON == $past(wdata[0]))
      else $error("rounding target does not follow write");
   // the three-stage sample pipe only relates in to out once reset has been high for three edges
   marker_lat_a: assert property ($past(RST_B, 3) && $past(RST_B, 2) && $past(RST_B) // see RL5
                                  && $past(sample_marker_insert) && !$past(SAMPLE_8BIT, 3)
                                  |-> SAMPLE_OUT[0] == $past(MARKER_PIN, 3))
      else $error("marker misaligned with sample");
   marker_data_a: assert property ($past(RST_B, 3) && $past(RST_B, 2) && $past(RST_B) // see RL6
                                   && $past(sample_marker_insert) && $past(SAMPLE_8BIT, 3)
                                   |-> SAMPLE_OUT[11:5] == $past(SAMPLE_IN[11:5], 3))
      else $error("8-bit sample data lost");
   marker_off_a: assert property ($past(RST_B, 3) && $past(RST_B, 2) && $past(RST_B) // see RL4
                                  && !$past(sample_marker_insert) |-> SAMPLE_OUT == $past(SAMPLE_IN, 3))
      else $error("sample altered without marker");
   ila_zero_a: assert property (ILA_CS == 2'h0) // see RL7
      else $error("control bits advertised");
   link_off_a: assert property (!serial_link_on |=> LINK_RESET && SERIALIZER_PD && !LINK_CLK_GATE_EN) // see RL10
      else $error("link not held off");
   link_wr_a: assert property (wr_stb && acc_addr == dslc_pkg::ADDR_LINK_EN // see RL9
                               |=> ##1 LINK_CLK_GATE_EN == $past(wdata[0], 2))
      else $error("link enable not applied");
   mf_hold_a: assert property (!serial_link_on |=> MF_COUNT == 8'h00 && !MF_START) // see RL11
      else $error("multiframe counter ran with link off");
   mode_lock_a: assert property (wr_stb && acc_addr == dslc_pkg::ADDR_LINK_MODE // see RL17
                                 && !mode_allowed(wdata, ALLOWED_MODES) |=> $stable(LINK_MODE))
      else $error("disallowed mode taken");
   mode_reset_a: assert property (!$past(RST_B) |-> LINK_MODE == dslc_pkg::RST_LINK_MODE) // see RL15
      else $error("link mode reset value wrong");
   k_src_a: assert property (MODE_IS_64B66B |=> FRAMES_PER_MF_M1 == $past(K_FROM_MODE_M1)) // see RL18
      else $error("K not taken from mode");
   resv_keep_a: assert property (wr_stb && acc_addr == dslc_pkg::ADDR_MARKER // see RL19
                                 |=> sample_marker_control == $past(wdata))
      else $error("marker byte not stored whole");

   marker_seen_c: cover property (sample_marker_insert && marker_s[1] ##1 SAMPLE_OUT[0]);
   mode_taken_c: cover property (wr_stb && acc_addr == dslc_pkg::ADDR_LINK_MODE ##1 $changed(LINK_MODE));
   mf_wrap_c: cover property (MF_START && !sysref_rise);
endmodule : dslc_regs

// ==== core/dslc_pkg.sv ====
// constants shared by the dither and serial link control register bank
package dslc_pkg;
   // register offsets on the serial control port
   localparam logic [14:0] ADDR_DITHER     = 15'h009d;
   localparam logic [14:0] ADDR_MARKER     = 15'h0160;
   localparam logic [14:0] ADDR_LINK_EN    = 15'h0200;
   localparam logic [14:0] ADDR_LINK_MODE  = 15'h0201;
   localparam logic [14:0] ADDR_MF_LEN     = 15'h0202;
   // reset values
   localparam logic [7:0]  RST_DITHER      = 8'h01;
   localparam logic [7:0]  RST_MARKER      = 8'h00;
   localparam logic [7:0]  RST_LINK_EN     = 8'h01;
   localparam logic [7:0]  RST_LINK_MODE   = 8'h02;
   localparam logic [7:0]  RST_MF_LEN      = 8'h1f;
   // field positions
   localparam int          DITHER_ON_BIT   = 0;
   localparam int          DITHER_SIZE_BIT = 1;
   localparam int          ROUND_ERR_BIT   = 2;
   localparam int          MARKER_BIT      = 0;
   localparam int          LINK_ON_BIT     = 0;
   // serial control port frame: read flag, 15-bit address, 8-bit data
   localparam int          SPI_ADDR_W      = 15;
   localparam int          SPI_DATA_W      = 8;
   localparam logic [4:0]  SPI_HDR_BITS    = 5'h10;
   localparam logic [4:0]  SPI_FRAME_BITS  = 5'h18;
   // sample path
   localparam int          SAMPLE_W        = 12;
   localparam int          MARK_POS_12     = 0;
   localparam int          MARK_POS_8      = 4;
   localparam int          MODE_ALLOW_W    = 64;
   localparam logic [7:0]  MODE_LIMIT      = 8'h40;
   // marker pin synchroniser and sample delay line share this depth
   localparam int          SYNC_DEPTH      = 2;

   typedef enum {SPI_HEADER, SPI_DATA, SPI_DONE} dslc_spi_e;
endpackage : dslc_pkg

// ==== core/dslc_spi.sv ====
// serial control port slave, oversampled on the reference clock
`timescale 1ns/10ps
module dslc_spi
(
   // clock and reset
   input  wire  logic                             clk,
   input  wire  logic                             rst_b,
   // pins, asynchronous to clk
   input  wire  logic                             sclk_pin,
   input  wire  logic                             scs_b_pin,
   input  wire  logic                             sdi_pin,
   output logic                                   sdo,
   output logic                                   sdo_oe,
   // register access
   output logic                                   wr_stb,
   output logic [dslc_pkg::SPI_ADDR_W-1:0]        acc_addr,
   output logic [dslc_pkg::SPI_DATA_W-1:0]        wdata,
   input  wire  logic [dslc_pkg::SPI_DATA_W-1:0]  rdata
);
   logic [1:0]                     sclk_s;
   logic [1:0]                     scs_s;
   logic [1:0]                     sdi_s;
   logic                           sclk_d;
   logic [4:0]                     bit_cnt;
   logic [22:0]                    shreg;
   logic                           rd_op;
   logic                           load_rd;
   logic [dslc_pkg::SPI_DATA_W-1:0] rd_shift;
   logic                           rise;
   logic                           fall;
   dslc_pkg::dslc_spi_e            state;

   // two flops per pin, plus a third on sclk for edge detection; the first stage is never looked at
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sclk_s <= 2'h0;
         scs_s  <= 2'h3;
         sdi_s  <= 2'h0;
         sclk_d <= 1'b0;
      end
      else
      begin
         sclk_s <= {sclk_s[0], sclk_pin};
         scs_s  <= {scs_s[0], scs_b_pin};
         sdi_s  <= {sdi_s[0], sdi_pin};
         sclk_d <= sclk_s[1];
      end
   end

   assign rise = sclk_s[1] & ~sclk_d;
   assign fall = ~sclk_s[1] & sclk_d;

   // bits beyond one frame are ignored until chip select rises
   always_ff @(posedge clk)
   begin
      if (!rst_b || scs_s[1])
      begin
         state    <= dslc_pkg::SPI_HEADER;
         bit_cnt  <= 5'h00;
         shreg    <= 23'h000000;
         rd_op    <= 1'b0;
         acc_addr <= 15'h0000;
         wdata    <= 8'h00;
         wr_stb   <= 1'b0;
         load_rd  <= 1'b0;
      end
      else
      begin
         wr_stb  <= 1'b0;
         load_rd <= 1'b0;
         if (rise && state != dslc_pkg::SPI_DONE)
         begin
            shreg   <= {shreg[21:0], sdi_s[1]};
            bit_cnt <= bit_cnt + 5'h01;
         end
         unique case (state)
            dslc_pkg::SPI_HEADER:
               if (rise && bit_cnt == dslc_pkg::SPI_HDR_BITS - 5'h01)
               begin
                  rd_op    <= shreg[14];
                  acc_addr <= {shreg[13:0], sdi_s[1]};
                  load_rd  <= shreg[14];
                  state    <= dslc_pkg::SPI_DATA;
               end
            dslc_pkg::SPI_DATA:
               if (rise && bit_cnt == dslc_pkg::SPI_FRAME_BITS - 5'h01)
               begin
                  wdata  <= {shreg[6:0], sdi_s[1]};
                  wr_stb <= ~rd_op;
                  state  <= dslc_pkg::SPI_DONE;
               end
            dslc_pkg::SPI_DONE:
               state <= dslc_pkg::SPI_DONE;
         endcase
      end
   end

   // read data leaves msb first on falling edges of the serial clock
   always_ff @(posedge clk)
   begin
      if (!rst_b || scs_s[1])
      begin
         rd_shift <= 8'h00;
         sdo      <= 1'b0;
         sdo_oe   <= 1'b0;
      end
      else if (load_rd)
      begin
         rd_shift <= rdata;
         sdo_oe   <= 1'b1;
      end
      else if (fall && rd_op && state == dslc_pkg::SPI_DATA)
      begin
         sdo      <= rd_shift[7];
         rd_shift <= {rd_shift[6:0], 1'b0};
      end
   end
endmodule : dslc_spi

// ==== verification/tb_top.sv ====
// self-checking testbench for the dither and serial link control register bank
`timescale 1ns/10ps
module tb_top;
   logic                   REF_CLK, RST_B, SCLK, SCS_B, SDI, SDO, SDO_OE, CAL_ON, MODE_IS_64B66B;
   logic                   FRAME_TICK, SYSREF, SAMPLE_8BIT, MARKER_PIN, DITHER_ON, DITHER_SIZE_SEL;
   logic                   ROUNDING_ERROR_TARGET, LINK_RESET, SERIALIZER_PD, LINK_CLK_GATE_EN, MF_START;
   logic [63:0]            ALLOWED_MODES;
   logic [7:0]             K_FROM_MODE_M1, LINK_MODE, FRAMES_PER_MF_M1, MF_COUNT;
   logic [11:0]            SAMPLE_IN, SAMPLE_OUT;
   logic [1:0]             ILA_CS;
   int                     mismatches;
   int                     check_count;

   dslc_regs dut
   (
      .REF_CLK(REF_CLK), .RST_B(RST_B), .SCLK(SCLK), .SCS_B(SCS_B), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE),
      .CAL_ON(CAL_ON), .ALLOWED_MODES(ALLOWED_MODES), .MODE_IS_64B66B(MODE_IS_64B66B),
      .K_FROM_MODE_M1(K_FROM_MODE_M1), .FRAME_TICK(FRAME_TICK), .SYSREF(SYSREF), .SAMPLE_IN(SAMPLE_IN),
      .SAMPLE_8BIT(SAMPLE_8BIT), .MARKER_PIN(MARKER_PIN), .SAMPLE_OUT(SAMPLE_OUT), .DITHER_ON(DITHER_ON),
      .DITHER_SIZE_SEL(DITHER_SIZE_SEL), .ROUNDING_ERROR_TARGET(ROUNDING_ERROR_TARGET),
      .LINK_RESET(LINK_RESET), .SERIALIZER_PD(SERIALIZER_PD), .LINK_CLK_GATE_EN(LINK_CLK_GATE_EN),
      .LINK_MODE(LINK_MODE), .FRAMES_PER_MF_M1(FRAMES_PER_MF_M1), .MF_COUNT(MF_COUNT),
      .MF_START(MF_START), .ILA_CS(ILA_CS)
   );

   initial
   begin
      REF_CLK = 1'b0;
      forever #12.5 REF_CLK = ~REF_CLK;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask : tick

   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      if (mismatches == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // each sclk phase is 5 reference cycles, above the 4 the synchroniser needs
   task automatic spi(input logic rd, input logic [14:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
      logic [23:0] frame;
      frame = {rd, addr, wd};
      rdat = 8'h00;
      @(posedge REF_CLK);
      SCS_B <= 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         SCLK <= 1'b0;
         SDI <= frame[i];
         tick(5);
         SCLK <= 1'b1;
         tick(4);
         @(negedge REF_CLK);
         if (i < 8)
            rdat[i] = SDO;
         if (rd && i == 0)
            check("sdo_oe", {11'h000, SDO_OE}, 12'h001);
         tick(1);
      end
      SCLK <= 1'b0;
      tick(5);
      SCS_B <= 1'b1;
      tick(6);
   endtask : spi

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] x;
      spi(1'b0, a, d, x);
   endtask : wr

   task automatic rd_chk(input string what, input logic [14:0] a, input logic [7:0] exp);
      logic [7:0] x;
      spi(1'b1, a, 8'h00, x);
      check(what, {4'h0, x}, {4'h0, exp});
   endtask : rd_chk

   task automatic pulse(input int n);
      repeat (n)
      begin
         FRAME_TICK <= 1'b1;
         tick(1);
         FRAME_TICK <= 1'b0;
         tick(1);
      end
   endtask : pulse

   task automatic t_reset;
      check("dither_on", {11'h000, DITHER_ON}, 12'h001);
      check("dither_size", {11'h000, DITHER_SIZE_SEL}, 12'h000);
      check("round_err", {11'h000, ROUNDING_ERROR_TARGET}, 12'h000);
      check("gate_en", {11'h000, LINK_CLK_GATE_EN}, 12'h001);
      check("link_mode", {4'h0, LINK_MODE}, 12'h002);
      check("k_m1", {4'h0, FRAMES_PER_MF_M1}, 12'h01f);
      rd_chk("rd_dither", dslc_pkg::ADDR_DITHER, 8'h01);
      rd_chk("rd_marker", dslc_pkg::ADDR_MARKER, 8'h00);
      rd_chk("rd_link_en", dslc_pkg::ADDR_LINK_EN, 8'h01);
      rd_chk("rd_k_m1", dslc_pkg::ADDR_MF_LEN, 8'h1f);
      rd_chk("rd_unmapped", 15'h0100, 8'h00);
      check("sdo_oe_idle", {11'h000, SDO_OE}, 12'h000);
   endtask : t_reset

   task automatic t_dither;
      wr(dslc_pkg::ADDR_DITHER, 8'hfe);
      check("dither_off", {11'h000, DITHER_ON}, 12'h000);
      check("dither_big", {11'h000, DITHER_SIZE_SEL}, 12'h001);
      check("round_dc", {11'h000, ROUNDING_ERROR_TARGET}, 12'h001);
      rd_chk("rd_dither_rsv", dslc_pkg::ADDR_DITHER, 8'hfe);
      wr(dslc_pkg::ADDR_DITHER, 8'h01);
   endtask : t_dither

   task automatic t_marker;
      SAMPLE_IN <= 12'hfff;
      wr(dslc_pkg::ADDR_MARKER, 8'h01); // sync receiver enable lives outside this bank
      check("mark_12", SAMPLE_OUT, 12'hffe);
      check("ila_cs", {10'h000, ILA_CS}, 12'h000);
      SAMPLE_8BIT <= 1'b1;
      tick(6);
      check("mark_8", SAMPLE_OUT, 12'hfef);
      SAMPLE_IN <= 12'h0a0;
      SAMPLE_8BIT <= 1'b0;
      MARKER_PIN <= 1'b1;
      tick(2);
      #1;
      check("mark_old", SAMPLE_OUT, 12'hfef);
      tick(1);
      #1;
      check("mark_new", SAMPLE_OUT, 12'h0a1);
      wr(dslc_pkg::ADDR_MARKER, 8'h00);
      check("mark_off", SAMPLE_OUT, 12'h0a0);
   endtask : t_marker

   task automatic t_link;
      wr(dslc_pkg::ADDR_LINK_MODE, 8'h05);
      check("mode_locked", {4'h0, LINK_MODE}, 12'h002);
      wr(dslc_pkg::ADDR_LINK_EN, 8'h00);
      check("link_rst", {11'h000, LINK_RESET}, 12'h001);
      check("ser_pd", {11'h000, SERIALIZER_PD}, 12'h001);
      check("gate_off", {11'h000, LINK_CLK_GATE_EN}, 12'h000);
      SYSREF <= 1'b1;
      pulse(3);
      tick(4);
      check("mf_held", {4'h0, MF_COUNT}, 12'h000);
      SYSREF <= 1'b0;
      wr(dslc_pkg::ADDR_LINK_MODE, 8'h05);
      check("mode_cal_on", {4'h0, LINK_MODE}, 12'h002);
      CAL_ON <= 1'b0;
      wr(dslc_pkg::ADDR_LINK_MODE, 8'h05);
      check("mode_ok", {4'h0, LINK_MODE}, 12'h005);
      wr(dslc_pkg::ADDR_LINK_MODE, 8'h06);
      rd_chk("mode_denied", dslc_pkg::ADDR_LINK_MODE, 8'h05);
      wr(dslc_pkg::ADDR_MF_LEN, 8'h02);
      check("k_m1_reg", {4'h0, FRAMES_PER_MF_M1}, 12'h002);
      MODE_IS_64B66B <= 1'b1;
      tick(3);
      check("k_m1_mode", {4'h0, FRAMES_PER_MF_M1}, 12'h007);
      MODE_IS_64B66B <= 1'b0;
      CAL_ON <= 1'b1;
      wr(dslc_pkg::ADDR_LINK_EN, 8'h01);
      check("link_on", {11'h000, LINK_RESET}, 12'h000);
      pulse(1);
      check("mf_one", {4'h0, MF_COUNT}, 12'h001);
      SYSREF <= 1'b1;
      tick(6);
      check("mf_align", {4'h0, MF_COUNT}, 12'h000);
      pulse(2);
      check("mf_two", {4'h0, MF_COUNT}, 12'h002);
      FRAME_TICK <= 1'b1;
      tick(1);
      FRAME_TICK <= 1'b0;
      @(negedge REF_CLK);
      check("mf_wrap", {4'h0, MF_COUNT}, 12'h000);
      check("mf_start", {11'h000, MF_START}, 12'h001);
      tick(1);
      @(negedge REF_CLK);
      check("mf_start_end", {11'h000, MF_START}, 12'h000);
   endtask : t_link

   initial
   begin
      mismatches = 0;
      check_count = 0;
      RST_B = 1'b0;
      SCLK = 1'b0;
      SCS_B = 1'b1;
      SDI = 1'b0;
      CAL_ON = 1'b1;
      ALLOWED_MODES = 64'h0000_0000_0000_0024;
      MODE_IS_64B66B = 1'b0;
      K_FROM_MODE_M1 = 8'h07;
      FRAME_TICK = 1'b0;
      SYSREF = 1'b0;
      SAMPLE_IN = 12'h000;
      SAMPLE_8BIT = 1'b0;
      MARKER_PIN = 1'b0;
      tick(2);
      RST_B <= 1'b1;
      tick(3);
      t_reset();
      t_dither();
      t_marker();
      t_link();
      wrap_up();
   end

   // the whole run needs about 4600 cycles
   initial
   begin
      tick(20000);
      mismatches++;
      wrap_up();
   end
endmodule : tb_top
